// [rtl/ccss_mem_port.sv]
// memory clock side: performs one word access per request by handshake
module ccss_mem_port
    import ccss_pkg::*;
(
    // link clock and reset
    input  wire logic               mclk,
    input  wire logic               rstn,
    // request from core domain, toggle handshake
    input  wire logic               req_tgl,
    input  wire ccss_mreq_t         req,
    input  wire logic               tran_en_n,
    input  wire logic [1:0]         mode_n,
    output logic                    ack_tgl,
    output logic [31:0]             rdata,
    // memory pins
    output ccss_mreq_t              mem_req,
    output logic                    mem_valid,
    output logic                    translate_enable_n,
    output logic [1:0]              proc_mode_bits_n,
    input  wire logic               mem_done,
    input  wire logic [31:0]        mem_rdata
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        seen;
        logic        busy;
        logic        ack;
        logic [31:0] rd;
        ccss_mreq_t  mr;
        logic        tr;
        logic [1:0]  md;
    } ccss_mp_t;
    ccss_mp_t q, d;

    // issue when a fresh toggle arrives, answer when memory completes
    always_comb begin
        d    = q;
        d.s1 = req_tgl;
        d.s2 = q.s1;
        if (!q.busy && (q.s2 != q.seen)) begin
            d.seen = q.s2;
            d.busy = 1'b1;
            d.mr   = req;
        end else if (q.busy && mem_done) begin
            d.busy = 1'b0;
            d.rd   = mem_rdata;
            d.ack  = ~q.ack;
        end
        d.tr = tran_en_n;
        d.md = mode_n;
    end

    // registered on rising edge so these pins move while mclk high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.tr <= 1'b1;
            q.md <= 2'h3;
        end else begin
            q <= d;
        end
    end

    assign ack_tgl            = q.ack;
    assign rdata              = q.rd;
    assign mem_req            = q.mr;
    assign mem_valid          = q.busy;
    assign translate_enable_n = q.tr;
    assign proc_mode_bits_n   = q.md;
endmodule : ccss_mem_port

// [rtl/ccss_pkg.sv]
// package of constants and types for the cache clock switch sequencer
// What this block does
// - cache off: every read and write goes external, timed by memory clock.
// - cache off: N access L+A, S access A, transfers one L.
// - branch and trap 1L+3A; data op 1A, plus 2L for register shift.
// - load 3L+2A, store 2L+2A; each plus 2A when pc involved.
// - multiply (m+1)L+1A; m is 1 for multiplier 0 or 1, at most 16.
// - coprocessor costs add b busy-wait latent cycles; data op (b+2)L+1A.
// - failed condition: no execution, exactly one active cycle.
// - cache on: run on core clock, serve fetches from cache.
// - cache read hit completes in one fast cycle.
// - cacheable read miss: switch to memory clock, fetch four-word line.
// - during line fetch, clock processor when requested word arrives.
// - rest of line fetch, clock sequential reads and internal operations.
// - uncacheable read goes external; stay while sequential reads continue.
// - swap bypasses cache and always reads externally.
// - writes go external; return to core clock after sequential writes stop.
// - cache on: internal operations take one fast cycle, some absorbed.
// - cache on: coprocessor transfers take one fast cycle.
// - drive line-fetch and lock indicator outputs.
// - translate-enable and mode outputs change only while memory clock high.
package ccss_pkg;
    localparam int unsigned ADDR_W       = 26;
    localparam int unsigned LINE_WORDS   = 4;
    localparam int unsigned MUL_M_MAX    = 16;
    localparam int unsigned CNT_W        = 8;

    // processor operation kinds
    typedef enum logic [2:0] {
        CCSS_OP_READ   = 3'h0,
        CCSS_OP_WRITE  = 3'h1,
        CCSS_OP_INTNL  = 3'h2,
        CCSS_OP_TRNSF  = 3'h3
    } ccss_op_t;

    // instruction classes for cache-off cost
    typedef enum logic [3:0] {
        CCSS_I_BRANCH = 4'h0,
        CCSS_I_DATA   = 4'h1,
        CCSS_I_MUL    = 4'h2,
        CCSS_I_LDR    = 4'h3,
        CCSS_I_STR    = 4'h4,
        CCSS_I_SWI    = 4'h5,
        CCSS_I_CDO    = 4'h6
    } ccss_instr_t;

    // processor request
    typedef struct packed {
        logic              valid;
        ccss_op_t          op;
        logic              seq;
        logic              cacheable;
        logic              swap;
        logic [ADDR_W-1:0] addr;
    } ccss_req_t;

    // memory side request toward link domain
    typedef struct packed {
        logic              write;
        logic              seq;
        logic              lock;
        logic              line;
        logic [ADDR_W-1:0] addr;
    } ccss_mreq_t;

    // cache-off cost in latent and active cycles
    typedef struct packed {
        logic [CNT_W-1:0] lat;
        logic [CNT_W-1:0] act;
    } ccss_cost_t;

    // core domain states, gray in listed order
    typedef enum logic [2:0] {
        CCSS_S_CORE  = 3'b000,
        CCSS_S_SYNC  = 3'b001,
        CCSS_S_LINE  = 3'b011,
        CCSS_S_EXT   = 3'b010,
        CCSS_S_COST  = 3'b110
    } ccss_state_t;
endpackage : ccss_pkg

// [rtl/ccss_top.sv]
// core clock sequencer deciding cache or external memory for each operation
module ccss_top
    import ccss_pkg::*;
(
    // core clock, reset, enable
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    // memory clock domain
    input  wire logic               mclk,
    // configuration
    input  wire logic               cache_enable,
    // processor request and cost query
    input  wire ccss_req_t          proc_req,
    input  wire ccss_instr_t        instr,
    input  wire logic               cond_pass,
    input  wire logic               shift_by_reg,
    input  wire logic               pc_involved,
    input  wire logic [4:0]         mul_m,
    input  wire logic [CNT_W-1:0]   busy_wait,
    input  wire logic               tran_en_n_in,
    input  wire logic [1:0]         mode_n_in,
    // cache lookup
    input  wire logic               cache_hit,
    input  wire logic [31:0]        cache_rdata,
    // processor answers
    output logic                    proc_clk_en,
    output logic [31:0]             proc_rdata,
    output logic                    on_mem_clock,
    output ccss_cost_t              instr_cost,
    // cache fill
    output logic                    fill_we,
    output logic [ADDR_W-1:0]       fill_addr,
    output logic [31:0]             fill_data,
    // memory pins
    output ccss_mreq_t              mem_req,
    output logic                    mem_valid,
    output logic                    line_fetch,
    output logic                    swap_lock,
    output logic                    translate_enable_n,
    output logic [1:0]              proc_mode_bits_n,
    input  wire logic               mem_done,
    input  wire logic [31:0]        mem_rdata
);
    // cache-off cost for one instruction
    function automatic ccss_cost_t cost_of(input ccss_instr_t i, input logic pass,
                                           input logic shr, input logic pc,
                                           input logic [4:0] m,
                                           input logic [CNT_W-1:0] b);
        ccss_cost_t c;
        logic [4:0] mm;
        c  = '0;
        mm = (m == 5'h0) ? 5'h1 : ((m > 5'(MUL_M_MAX)) ? 5'(MUL_M_MAX) : m);
        if (!pass) begin
            c.act = 8'h01;
        end else begin
            unique case (i)
                CCSS_I_BRANCH, CCSS_I_SWI: begin
                    c.lat = 8'h01;
                    c.act = 8'h03;
                end
                CCSS_I_DATA: begin
                    c.act = 8'h01;
                    c.lat = shr ? 8'h02 : 8'h00;
                end
                CCSS_I_MUL: begin
                    c.lat = 8'(mm) + 8'h01;
                    c.act = 8'h01;
                end
                CCSS_I_LDR: begin
                    c.lat = 8'h03;
                    c.act = pc ? 8'h04 : 8'h02;
                end
                CCSS_I_STR: begin
                    c.lat = 8'h02;
                    c.act = pc ? 8'h04 : 8'h02;
                end
                CCSS_I_CDO: begin
                    c.lat = b + 8'h02;
                    c.act = 8'h01;
                end
                default: c = '0;
            endcase
        end
        return c;
    endfunction : cost_of

    typedef struct packed {
        ccss_state_t       st;
        logic              tgl;
        logic              a1;
        logic              a2;
        logic              a_seen;
        logic              pending;
        logic [1:0]        widx;
        logic [1:0]        want;
        logic              got_want;
        logic              clk_en;
        logic [31:0]       rdata;
        logic              onm;
        ccss_cost_t        cost;
        logic              fwe;
        logic [ADDR_W-1:0] faddr;
        logic [31:0]       fdata;
        logic [ADDR_W-1:0] base;
        ccss_mreq_t        mr;
        logic              line_q;
        logic              lock_q;
        logic              ext_seq;
    } ccss_st_t;
    ccss_st_t q, d;

    logic        ack_tgl;
    logic [31:0] link_rdata;
    logic        ack_new;

    // link domain performs the word accesses
    ccss_mem_port u_mem (
        .mclk               (mclk),
        .rstn               (rstn),
        .req_tgl            (q.tgl),
        .req                (q.mr),
        .tran_en_n          (tran_en_n_in),
        .mode_n             (mode_n_in),
        .ack_tgl            (ack_tgl),
        .rdata              (link_rdata),
        .mem_req            (mem_req),
        .mem_valid          (mem_valid),
        .translate_enable_n (translate_enable_n),
        .proc_mode_bits_n   (proc_mode_bits_n),
        .mem_done           (mem_done),
        .mem_rdata          (mem_rdata)
    );

    // rdata stable once ack seen after two-flop toggle sync
    assign ack_new = (q.a2 != q.a_seen);

    // sequencer
    always_comb begin
        d        = q;
        d.a1     = ack_tgl;
        d.a2     = q.a1;
        d.clk_en = 1'b0;
        d.fwe    = 1'b0;
        d.cost   = cost_of(instr, cond_pass, shift_by_reg, pc_involved, mul_m, busy_wait);
        if (ack_new) begin
            d.a_seen  = q.a2;
            d.pending = 1'b0;
        end
        unique case (q.st)
            CCSS_S_CORE: begin
                d.onm = 1'b0;
                if (proc_req.valid) begin
                    if (!cache_enable) begin
                        d.st = CCSS_S_COST;
                    end else if (proc_req.op == CCSS_OP_INTNL
                                 || proc_req.op == CCSS_OP_TRNSF) begin
                        d.clk_en = 1'b1;
                    end else if (proc_req.op == CCSS_OP_READ && !proc_req.swap
                                 && cache_hit) begin
                        d.clk_en = 1'b1;
                        d.rdata  = cache_rdata;
                    end else begin
                        d.st = CCSS_S_SYNC;
                    end
                end
            end
            CCSS_S_SYNC: begin
                d.onm     = 1'b1;
                d.mr      = '0;
                d.mr.write = (proc_req.op == CCSS_OP_WRITE);
                d.mr.seq  = proc_req.seq;
                d.mr.lock = proc_req.swap;
                d.lock_q  = proc_req.swap;
                d.pending = 1'b1;
                d.tgl     = ~q.tgl;
                if (proc_req.op == CCSS_OP_READ && proc_req.cacheable && cache_enable
                    && !proc_req.swap) begin
                    d.base    = {proc_req.addr[ADDR_W-1:4], 4'h0};
                    d.want    = proc_req.addr[3:2];
                    d.widx    = 2'h0;
                    d.got_want = 1'b0;
                    d.mr.line = 1'b1;
                    d.mr.addr = {proc_req.addr[ADDR_W-1:4], 4'h0};
                    d.line_q  = 1'b1;
                    d.st      = CCSS_S_LINE;
                end else begin
                    d.mr.addr = proc_req.addr;
                    d.st      = CCSS_S_EXT;
                end
            end
            CCSS_S_LINE: begin
                if (ack_new) begin
                    d.fwe   = 1'b1;
                    d.faddr = q.base + ADDR_W'({q.widx, 2'h0});
                    d.fdata = link_rdata;
                    if (q.widx == q.want) begin
                        d.clk_en   = 1'b1;
                        d.rdata    = link_rdata;
                        d.got_want = 1'b1;
                    end else if (q.got_want && proc_req.valid
                                 && ((proc_req.op == CCSS_OP_READ && proc_req.seq)
                                     || proc_req.op == CCSS_OP_INTNL)) begin
                        d.clk_en = 1'b1;
                        d.rdata  = link_rdata;
                    end
                    if (q.widx == 2'(LINE_WORDS - 1)) begin
                        d.line_q = 1'b0;
                        d.st     = CCSS_S_CORE;
                    end else begin
                        d.widx     = q.widx + 2'h1;
                        d.mr.seq   = 1'b1;
                        d.mr.addr  = q.base + ADDR_W'({q.widx + 2'h1, 2'h0});
                        d.pending  = 1'b1;
                        d.tgl      = ~q.tgl;
                    end
                end
            end
            CCSS_S_EXT: begin
                if (ack_new) begin
                    d.clk_en = 1'b1;
                    d.rdata  = link_rdata;
                    d.lock_q = 1'b0;
                    d.st     = CCSS_S_CORE;
                    // stay on memory clock while sequential accesses continue
                    if (proc_req.valid && proc_req.seq && !proc_req.swap
                        && proc_req.op == (q.mr.write ? CCSS_OP_WRITE : CCSS_OP_READ)) begin
                        d.st = CCSS_S_SYNC;
                    end
                end
            end
            CCSS_S_COST: begin
                d.onm = 1'b1;
                if (!cache_enable && (proc_req.op == CCSS_OP_READ
                                      || proc_req.op == CCSS_OP_WRITE)) begin
                    d.st = CCSS_S_SYNC;
                end else begin
                    d.clk_en = 1'b1;
                    d.st     = CCSS_S_CORE;
                end
            end
            default: d.st = CCSS_S_CORE;
        endcase
    end

    // state register, frozen while ce low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign proc_clk_en = q.clk_en;
    assign proc_rdata  = q.rdata;
    assign on_mem_clock = q.onm;
    assign instr_cost  = q.cost;
    assign fill_we     = q.fwe;
    assign fill_addr   = q.faddr;
    assign fill_data   = q.fdata;
    assign line_fetch  = q.line_q;
    assign swap_lock   = q.lock_q;
endmodule : ccss_top

// [testbench/ccss_chk_sva.sv]
// assertion checker on the sequencer ports
module ccss_chk
    import ccss_pkg::*;
(
    // clocks and reset
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              mclk,
    // processor side
    input wire logic              cache_enable,
    input wire ccss_req_t         proc_req,
    input wire logic              cond_pass,
    input wire logic              cache_hit,
    input wire logic              proc_clk_en,
    input wire logic              on_mem_clock,
    input wire ccss_cost_t        instr_cost,
    // cache fill and indicators
    input wire logic              fill_we,
    input wire logic [ADDR_W-1:0] fill_addr,
    input wire logic              line_fetch,
    input wire logic              swap_lock,
    // memory side
    input wire ccss_mreq_t        mem_req,
    input wire logic              mem_valid,
    input wire logic              mem_done,
    input wire logic              translate_enable_n,
    input wire logic [1:0]        proc_mode_bits_n
);
    logic [2:0]        fcnt_q;
    logic              lf_q;
    logic [ADDR_W-1:0] fa_q;
    logic              te_q;
    logic [1:0]        md_q;
    logic              new_req;

    // request while no fetch or external run is pending
    assign new_req = proc_req.valid && !line_fetch && !on_mem_clock;

    // fills per line fetch, last fill address
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fcnt_q <= 3'h0;
            lf_q   <= 1'b0;
            fa_q   <= '0;
        end else begin
            lf_q <= line_fetch;
            if (line_fetch && !lf_q) fcnt_q <= {2'h0, fill_we};
            else if (fill_we) fcnt_q <= fcnt_q + 3'h1;
            if (fill_we) fa_q <= fill_addr;
        end
    end

    // mode outputs as left by the memory clock high phase
    always_ff @(negedge mclk or negedge rstn) begin
        if (!rstn) begin
            te_q <= 1'b1;
            md_q <= 2'h3;
        end else begin
            te_q <= translate_enable_n;
            md_q <= proc_mode_bits_n;
        end
    end

    a_hit_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
        $rose(proc_req.valid) && new_req && cache_enable && cache_hit && !proc_req.swap
        && proc_req.op == CCSS_OP_READ |=> proc_clk_en)
        else $error("cache hit not answered in one cycle");
    a_miss_line: assert property (@(posedge clk) disable iff (!rstn)
        $rose(proc_req.valid) && new_req && cache_enable && proc_req.cacheable && !cache_hit
        && !proc_req.swap && proc_req.op == CCSS_OP_READ |-> ##[1:40] line_fetch)
        else $error("cacheable miss started no line fetch");
    a_line_four: assert property (@(posedge clk) disable iff (!rstn)
        $fell(line_fetch) |-> fcnt_q == 3'h4 || (fcnt_q == 3'h3 && fill_we))
        else $error("line fetch did not fill four words");
    a_fill_ascend: assert property (@(posedge clk) disable iff (!rstn)
        fill_we && lf_q && fcnt_q != 3'h0 |-> fill_addr == fa_q + 26'h4)
        else $error("line words not ascending");
    a_write_ext: assert property (@(posedge clk) disable iff (!rstn)
        $rose(proc_req.valid) && proc_req.op == CCSS_OP_WRITE
        |-> ##[1:40] mem_valid && mem_req.write)
        else $error("write not sent to memory");
    a_swap_lock: assert property (@(posedge clk) disable iff (!rstn)
        $rose(proc_req.valid) && new_req && cache_enable && proc_req.swap
        |-> ##[1:40] swap_lock)
        else $error("swap without lock indicator");
    a_cond_fail: assert property (@(posedge clk) disable iff (!rstn)
        !cond_pass |=> instr_cost.lat == 8'h0 && instr_cost.act == 8'h1)
        else $error("failed condition cost wrong");
    a_mode_hi_only: assert property (@(posedge mclk) disable iff (!rstn)
        translate_enable_n == te_q && proc_mode_bits_n == md_q)
        else $error("mode outputs changed with memory clock low");

    // main scenarios reached
    c_line: cover property (@(posedge clk) disable iff (!rstn) $fell(line_fetch));
    c_lock: cover property (@(posedge clk) disable iff (!rstn) $rose(swap_lock));
    c_write: cover property (@(posedge mclk) disable iff (!rstn) mem_done && mem_req.write);
endmodule : ccss_chk

bind ccss_top ccss_chk i_chk (.clk, .rstn, .mclk, .cache_enable, .proc_req, .cond_pass,
    .cache_hit, .proc_clk_en, .on_mem_clock, .instr_cost, .fill_we, .fill_addr,
    .line_fetch, .swap_lock, .mem_req, .mem_valid, .mem_done, .translate_enable_n,
    .proc_mode_bits_n);

// [testbench/ccss_mem_model.sv]
// external memory model on the memory clock
module ccss_mem_model
    import ccss_pkg::*;
(
    // memory clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // three wait cycles per access when high
    input  wire logic       slow,
    // access from the sequencer
    input  wire ccss_mreq_t mem_req,
    input  wire logic       mem_valid,
    output logic            mem_done,
    output logic [31:0]     mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    int                acc_cnt;
    logic [1:0]        wait_q;
    logic [ADDR_W-1:0] addr_log [256];
    logic              wr_log [256];

    // answer one access, data inverted when idle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acc_cnt   <= 0;
            wait_q    <= 2'h0;
            mem_done  <= 1'b0;
            mem_rdata <= 32'h0;
        end else if (mem_done || !mem_valid) begin
            mem_done  <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (slow && wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            wait_q                 <= 2'h0;
            mem_done               <= 1'b1;
            mem_rdata              <= {6'h2A, mem_req.addr};
            addr_log[acc_cnt[7:0]] <= mem_req.addr;
            wr_log[acc_cnt[7:0]]   <= mem_req.write;
            acc_cnt                <= acc_cnt + 1;
        end
    end
endmodule : ccss_mem_model

// [testbench/tb_top.sv]
// self-checking bench for the cache clock switch sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ccss_pkg::*;

    logic              clk = 1'b0;
    logic              mclk = 1'b0;
    logic              rstn = 1'b0;
    logic              slow = 1'b0;
    logic              cache_enable = 1'b0;
    ccss_req_t         proc_req = '0;
    ccss_instr_t       instr = CCSS_I_DATA;
    logic              cond_pass = 1'b1;
    logic              shift_by_reg = 1'b0;
    logic              pc_involved = 1'b0;
    logic [4:0]        mul_m = 5'h0;
    logic [CNT_W-1:0]  busy_wait = '0;
    logic              tran_en_n_in = 1'b1;
    logic [1:0]        mode_n_in = 2'h3;
    logic              cache_hit = 1'b0;
    logic [31:0]       cache_rdata = 32'h0;
    logic              proc_clk_en, on_mem_clock, fill_we, line_fetch, swap_lock;
    logic              mem_valid, mem_done, translate_enable_n, lf_seen, lk_seen;
    logic [31:0]       proc_rdata, fill_data, mem_rdata, rd;
    logic [ADDR_W-1:0] fill_addr;
    logic [1:0]        proc_mode_bits_n;
    ccss_cost_t        instr_cost;
    ccss_mreq_t        mem_req;
    int                miscompares = 0;
    int                total_checks = 0;
    int                en_n, fills, en_fills, acc0;

    // core clock free running, memory clock unrelated in phase
    always #2 clk = ~clk;
    initial #1.3 forever #3 mclk = ~mclk;

    ccss_top i_dut (.clk, .rstn, .ce(1'b1), .mclk, .cache_enable, .proc_req, .instr,
        .cond_pass, .shift_by_reg, .pc_involved, .mul_m, .busy_wait, .tran_en_n_in,
        .mode_n_in, .cache_hit, .cache_rdata, .proc_clk_en, .proc_rdata, .on_mem_clock,
        .instr_cost, .fill_we, .fill_addr, .fill_data, .mem_req, .mem_valid, .line_fetch,
        .swap_lock, .translate_enable_n, .proc_mode_bits_n, .mem_done, .mem_rdata);
    ccss_mem_model i_mem (.mclk, .rstn, .slow, .mem_req, .mem_valid, .mem_done,
        .mem_rdata);

    // word pattern the memory model returns
    function automatic logic [31:0] md(input logic [ADDR_W-1:0] a);
        return {6'h2A, a};
    endfunction : md

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one request held until answered, line drained
    task automatic run_req(input ccss_op_t op, input logic cab, input logic sw,
                           input logic hit, input logic [ADDR_W-1:0] a);
        int n;
        @(posedge clk);
        #1;
        n = 0;
        fills = 0;
        en_n = 0;
        lf_seen = 1'b0;
        lk_seen = 1'b0;
        acc0 = i_mem.acc_cnt;
        proc_req = '{1'b1, op, 1'b0, cab, sw, a};
        cache_hit = hit;
        cache_rdata = ~md(a);
        while (n < 300 && (en_n == 0 || line_fetch)) begin
            @(posedge clk);
            #1;
            n++;
            lf_seen |= line_fetch;
            lk_seen |= swap_lock;
            if (fill_we) begin
                fills++;
                chk("fill_data", md(fill_addr), fill_data);
            end
            if (proc_clk_en && en_n == 0) begin
                en_n = n;
                en_fills = fills;
                rd = proc_rdata;
                proc_req.valid = 1'b0;
            end
        end
        chk("answered", 32'h1, {31'h0, en_n != 0});
    endtask : run_req

    task automatic t_hit();
        run_req(CCSS_OP_READ, 1'b1, 1'b0, 1'b1, 26'h100);
        chk("hit cycles", 32'h1, en_n);
        chk("hit data", ~md(26'h100), rd);
        chk("hit mem reads", acc0, i_mem.acc_cnt);
    endtask : t_hit

    task automatic t_intnl();
        run_req(CCSS_OP_INTNL, 1'b1, 1'b0, 1'b0, 26'h104);
        chk("internal cycles", 32'h1, en_n);
        run_req(CCSS_OP_TRNSF, 1'b1, 1'b0, 1'b0, 26'h108);
        chk("transfer cycles", 32'h1, en_n);
    endtask : t_intnl

    task automatic t_miss();
        run_req(CCSS_OP_READ, 1'b1, 1'b0, 1'b0, 26'h248);
        chk("line fills", 32'h4, fills);
        chk("miss data", md(26'h248), rd);
        chk("early answer", 32'h1, {31'h0, en_fills < 4});
        chk("line seen", 32'h1, {31'h0, lf_seen});
        chk("line first", 32'h240, {6'h0, i_mem.addr_log[acc0]});
        chk("line last", 32'h24C, {6'h0, i_mem.addr_log[acc0 + 3]});
    endtask : t_miss

    task automatic t_uncache();
        slow = 1'b1;
        run_req(CCSS_OP_READ, 1'b0, 1'b0, 1'b0, 26'h380);
        chk("uncached data", md(26'h380), rd);
        chk("uncached fills", 32'h0, fills);
        slow = 1'b0;
    endtask : t_uncache

    task automatic t_swap();
        run_req(CCSS_OP_READ, 1'b1, 1'b1, 1'b1, 26'h3A0);
        chk("swap data", md(26'h3A0), rd);
        chk("lock seen", 32'h1, {31'h0, lk_seen});
    endtask : t_swap

    task automatic t_write();
        tran_en_n_in = 1'b0;
        mode_n_in = 2'h1;
        run_req(CCSS_OP_WRITE, 1'b1, 1'b0, 1'b1, 26'h3C0);
        chk("write kind", 32'h1, {31'h0, i_mem.wr_log[acc0]});
        chk("write addr", 32'h3C0, {6'h0, i_mem.addr_log[acc0]});
        chk("translate", 32'h0, {31'h0, translate_enable_n});
        chk("mode", 32'h1, {30'h0, proc_mode_bits_n});
    endtask : t_write

    task automatic t_off();
        cache_enable = 1'b0;
        run_req(CCSS_OP_READ, 1'b1, 1'b0, 1'b1, 26'h500);
        chk("off data", md(26'h500), rd);
        chk("off mem reads", acc0 + 1, i_mem.acc_cnt);
        chk("onm", 32'h1, {31'h0, on_mem_clock});
    endtask : t_off

    // flags are condition, register shift, pc involved
    task automatic cost(input ccss_instr_t i, input logic [2:0] f, input logic [4:0] m,
                        input logic [7:0] b, input logic [7:0] lat, input logic [7:0] act);
        instr = i;
        {cond_pass, shift_by_reg, pc_involved} = f;
        mul_m = m;
        busy_wait = b;
        @(posedge clk);
        #1;
        @(posedge clk);
        #1;
        chk("instr_cost", {16'h0, lat, act}, {16'h0, instr_cost});
    endtask : cost

    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        cache_enable = 1'b1;
        t_hit();
        t_intnl();
        t_miss();
        t_uncache();
        t_swap();
        t_write();
        t_off();
        cost(CCSS_I_BRANCH, 3'h4, 5'h0, 8'h0, 8'h1, 8'h3);
        cost(CCSS_I_SWI, 3'h4, 5'h0, 8'h0, 8'h1, 8'h3);
        cost(CCSS_I_DATA, 3'h4, 5'h0, 8'h0, 8'h0, 8'h1);
        cost(CCSS_I_DATA, 3'h6, 5'h0, 8'h0, 8'h2, 8'h1);
        cost(CCSS_I_LDR, 3'h4, 5'h0, 8'h0, 8'h3, 8'h2);
        cost(CCSS_I_LDR, 3'h5, 5'h0, 8'h0, 8'h3, 8'h4);
        cost(CCSS_I_STR, 3'h4, 5'h0, 8'h0, 8'h2, 8'h2);
        cost(CCSS_I_MUL, 3'h4, 5'h0, 8'h0, 8'h2, 8'h1);
        cost(CCSS_I_MUL, 3'h4, 5'h10, 8'h0, 8'h11, 8'h1);
        cost(CCSS_I_CDO, 3'h4, 5'h0, 8'h3, 8'h5, 8'h1);
        cost(CCSS_I_LDR, 3'h1, 5'h0, 8'h0, 8'h0, 8'h1);
        results();
    end

    // watchdog against a hang
    initial begin
        #100000;
        miscompares++;
        results();
    end
endmodule : tb_top
